// file: common/wide_arith_consts.svh
`ifndef WIDE_ARITH_CONSTS_SVH
`define WIDE_ARITH_CONSTS_SVH
// Prefix bytes
`define PREFIX_X 8'hdd
`define PREFIX_Y 8'hfd
// Opcodes
`define OP_INC_INDEX 8'h23
`define OP_DEC_INDEX 8'h2b
`define OP_ROT_LC 8'h07
`define OP_ROT_RC 8'h0f
`define OP_ROT_LT 8'h17
`define OP_ROT_RT 8'h1f
// Operand field layout: 00ss0011, 00ss1011, 00rr1001
`define PAIR_FIELD_HI 5
`define PAIR_FIELD_LO 4
`define LOW_NIBBLE_INC 4'h3
`define LOW_NIBBLE_DEC 4'hb
`define LOW_NIBBLE_ADD 4'h9
// Flag bit positions in the flag byte
`define FLAG_CARRY 0
`define FLAG_SUB 1
`define FLAG_PV 2
`define FLAG_HALF 4
`define FLAG_ZERO 6
`define FLAG_SIGN 7
// Carry-out bit positions of the wide add
`define HALF_CARRY_BIT 11
`define FULL_CARRY_BIT 15
// Clock-state counts
`define TS_ADD_INDEX 5'd15
`define TS_INC_DEC_PAIR 5'd6
`define TS_INC_DEC_INDEX 5'd10
`define TS_ROTATE 5'd4
`define TS_FIRST_MCYCLE 5'd4
// Reset values
`define RESET_WORD 16'h0000
`define RESET_BYTE 8'h00
`endif

// file: common/wide_arith_pkg.sv
package wide_arith_pkg;
	typedef enum logic [1:0] {
		SEL_PAIR_B_C = 2'b00,
		SEL_PAIR_D_E = 2'b01,
		SEL_PAIR_HIGH_LOW = 2'b10,
		SEL_STACK_POINTER = 2'b11
	} pair_sel_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PREFIX = 2'b01,
		ST_BUSY = 2'b10
	} phase_t;

	typedef enum logic [3:0] {
		OPK_NONE = 4'h0,
		OPK_ADD_Y = 4'h1,
		OPK_INC_PAIR = 4'h2,
		OPK_DEC_PAIR = 4'h3,
		OPK_INC_X = 4'h4,
		OPK_DEC_X = 4'h5,
		OPK_INC_Y = 4'h6,
		OPK_DEC_Y = 4'h7,
		OPK_ROT_LC = 4'h8,
		OPK_ROT_LT = 4'h9,
		OPK_ROT_RC = 4'ha,
		OPK_ROT_RT = 4'hb
	} op_kind_t;
endpackage

// file: design/acc_rotator.sv
`timescale 1ns/1ps
`default_nettype none
`include "wide_arith_consts.svh"
module acc_rotator (
	// Operation select
	input wire logic left,
	input wire logic through_carry,
	// Operands
	input wire logic [7:0] acc_in,
	input wire logic carry_in,
	// Results
	output logic [7:0] acc_out,
	output logic carry_out
);
	always_comb begin
		if (left) begin
			acc_out = {acc_in[6:0], through_carry ? carry_in : acc_in[7]};
			carry_out = acc_in[7];
		end else begin
			acc_out = {through_carry ? carry_in : acc_in[0], acc_in[7:1]};
			carry_out = acc_in[0];
		end
	end
endmodule
`default_nettype wire

// file: design/wide_arith_unit.sv
// Operation
// - Prefix FD then 00rr1001 adds selected pair into index_reg_y, 15 states.
// - That add sets half carry from bit 11, carry from bit 15, clears subtract.
// - 00ss0011 increments the selected pair in 6 states, flags untouched.
// - DD then 23 increments index_reg_x in 10 states, flags untouched.
// - FD then 23 increments index_reg_y in 10 states, flags untouched.
// - 00ss1011 decrements the selected pair in 6 states, flags untouched.
// - DD then 2B decrements index_reg_x in 10 states, flags untouched.
// - FD then 2B decrements index_reg_y in 10 states, flags untouched.
// - Circular left rotate moves old bit 7 to bit 0 and carry, 4 states.
// - Opcode 17 rotates left through carry, old carry into bit 0, 4 states.
// - Circular right rotate moves old bit 0 to bit 7 and carry, 4 states.
// - Left rotates: carry gets old bit 7, clear half carry and subtract.
// - Right rotates: carry gets old bit 0, clear half carry and subtract.
// - Right rotate through carry puts old carry into bit 7, 4 states.
`timescale 1ns/1ps
`default_nettype none
`include "wide_arith_consts.svh"
module wide_arith_unit (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Instruction byte stream from the fetch stage
	input wire logic op_valid,
	input wire logic [7:0] op_byte,
	// Register file load
	input wire logic load_en,
	input wire logic [15:0] load_pair_b_c,
	input wire logic [15:0] load_pair_d_e,
	input wire logic [15:0] load_pair_high_low,
	input wire logic [15:0] load_stack_pointer,
	input wire logic [15:0] load_index_reg_x,
	input wire logic [15:0] load_index_reg_y,
	input wire logic [7:0] load_acc,
	input wire logic [7:0] load_flags,
	// Register file view
	output logic [15:0] pair_b_c,
	output logic [15:0] pair_d_e,
	output logic [15:0] pair_high_low,
	output logic [15:0] stack_pointer,
	output logic [15:0] index_reg_x,
	output logic [15:0] index_reg_y,
	output logic [7:0] acc,
	output logic [7:0] flags,
	// Status
	output logic busy,
	output logic done,
	output logic unknown_op
);
	typedef struct packed {
		wide_arith_pkg::phase_t phase;
		logic prefix_y;
		logic [1:0] pair_field;
		wide_arith_pkg::op_kind_t kind;
		logic [4:0] tstate;
		logic [4:0] length;
		logic [15:0] r_bc;
		logic [15:0] r_de;
		logic [15:0] r_hl;
		logic [15:0] r_sp;
		logic [15:0] r_ix;
		logic [15:0] r_iy;
		logic [7:0] r_acc;
		logic [7:0] r_flags;
		logic busy;
		logic done;
		logic unknown_op;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic rot_left;
	logic rot_thru;
	logic [7:0] rot_acc;
	logic rot_carry;
	logic [15:0] add_src;
	logic [16:0] add_sum;
	logic [12:0] add_low;

	acc_rotator acc_rotator_inst (
		.left(rot_left),
		.through_carry(rot_thru),
		.acc_in(state_reg.r_acc),
		.carry_in(state_reg.r_flags[`FLAG_CARRY]),
		.acc_out(rot_acc),
		.carry_out(rot_carry)
	);

	assign rot_left = (state_reg.kind == wide_arith_pkg::OPK_ROT_LC) ||
		(state_reg.kind == wide_arith_pkg::OPK_ROT_LT);
	assign rot_thru = (state_reg.kind == wide_arith_pkg::OPK_ROT_LT) ||
		(state_reg.kind == wide_arith_pkg::OPK_ROT_RT);

	// Operand for the wide add; code 10 names index_reg_y itself
	always_comb begin
		case (wide_arith_pkg::pair_sel_t'(state_reg.pair_field))
			wide_arith_pkg::SEL_PAIR_B_C: add_src = state_reg.r_bc;
			wide_arith_pkg::SEL_PAIR_D_E: add_src = state_reg.r_de;
			wide_arith_pkg::SEL_PAIR_HIGH_LOW: add_src = state_reg.r_iy;
			wide_arith_pkg::SEL_STACK_POINTER: add_src = state_reg.r_sp;
			default: add_src = state_reg.r_bc;
		endcase
	end

	assign add_sum = {1'b0, state_reg.r_iy} + {1'b0, add_src};
	assign add_low = {1'b0, state_reg.r_iy[11:0]} + {1'b0, add_src[11:0]};

	function automatic logic [15:0] step(input logic [15:0] v, input logic up);
		return up ? v + 16'h0001 : v - 16'h0001;
	endfunction

	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		state_next.unknown_op = 1'b0;
		case (state_reg.phase)
			wide_arith_pkg::ST_IDLE, wide_arith_pkg::ST_PREFIX: begin
				if (load_en && state_reg.phase == wide_arith_pkg::ST_IDLE) begin
					state_next.r_bc = load_pair_b_c;
					state_next.r_de = load_pair_d_e;
					state_next.r_hl = load_pair_high_low;
					state_next.r_sp = load_stack_pointer;
					state_next.r_ix = load_index_reg_x;
					state_next.r_iy = load_index_reg_y;
					state_next.r_acc = load_acc;
					state_next.r_flags = load_flags;
				end else if (op_valid) begin
					state_next.kind = wide_arith_pkg::OPK_NONE;
					state_next.tstate = 5'd1;
					// Pair field rides with every accepted byte, held while busy
					state_next.pair_field = op_byte[`PAIR_FIELD_HI:`PAIR_FIELD_LO];
					if (state_reg.phase == wide_arith_pkg::ST_IDLE) begin
						if (op_byte == `PREFIX_X || op_byte == `PREFIX_Y) begin
							state_next.phase = wide_arith_pkg::ST_PREFIX;
							state_next.prefix_y = (op_byte == `PREFIX_Y);
						end else if (op_byte[7:6] == 2'b00 && op_byte[3:0] == `LOW_NIBBLE_INC) begin
							state_next.kind = wide_arith_pkg::OPK_INC_PAIR;
							state_next.length = `TS_INC_DEC_PAIR;
						end else if (op_byte[7:6] == 2'b00 && op_byte[3:0] == `LOW_NIBBLE_DEC) begin
							state_next.kind = wide_arith_pkg::OPK_DEC_PAIR;
							state_next.length = `TS_INC_DEC_PAIR;
						end else if (op_byte == `OP_ROT_LC) begin
							state_next.kind = wide_arith_pkg::OPK_ROT_LC;
						end else if (op_byte == `OP_ROT_LT) begin
							state_next.kind = wide_arith_pkg::OPK_ROT_LT;
						end else if (op_byte == `OP_ROT_RC) begin
							state_next.kind = wide_arith_pkg::OPK_ROT_RC;
						end else if (op_byte == `OP_ROT_RT) begin
							state_next.kind = wide_arith_pkg::OPK_ROT_RT;
						end else begin
							state_next.unknown_op = 1'b1;
						end
						if (state_next.kind >= wide_arith_pkg::OPK_ROT_LC) begin
							state_next.length = `TS_ROTATE;
						end
					end else begin
						state_next.phase = wide_arith_pkg::ST_IDLE;
						if (op_byte == `OP_INC_INDEX) begin
							state_next.kind = state_reg.prefix_y ? wide_arith_pkg::OPK_INC_Y :
								wide_arith_pkg::OPK_INC_X;
							state_next.length = `TS_INC_DEC_INDEX;
						end else if (op_byte == `OP_DEC_INDEX) begin
							state_next.kind = state_reg.prefix_y ? wide_arith_pkg::OPK_DEC_Y :
								wide_arith_pkg::OPK_DEC_X;
							state_next.length = `TS_INC_DEC_INDEX;
						end else if (state_reg.prefix_y && op_byte[7:6] == 2'b00 &&
							op_byte[3:0] == `LOW_NIBBLE_ADD) begin
							state_next.kind = wide_arith_pkg::OPK_ADD_Y;
							state_next.length = `TS_ADD_INDEX;
						end else begin
							state_next.unknown_op = 1'b1;
						end
					end
					if (state_next.kind != wide_arith_pkg::OPK_NONE) begin
						state_next.phase = wide_arith_pkg::ST_BUSY;
						state_next.busy = 1'b1;
						if (state_next.length != `TS_ADD_INDEX &&
							state_next.length != `TS_INC_DEC_PAIR &&
							state_next.length != `TS_INC_DEC_INDEX) begin
							state_next.length = `TS_ROTATE;
						end
					end
				end
			end
			wide_arith_pkg::ST_BUSY: begin
				state_next.tstate = state_reg.tstate + 5'd1;
				if (state_reg.tstate == state_reg.length - 5'd1) begin
					state_next.phase = wide_arith_pkg::ST_IDLE;
					state_next.busy = 1'b0;
					state_next.done = 1'b1;
					state_next.kind = wide_arith_pkg::OPK_NONE;
					case (state_reg.kind)
						wide_arith_pkg::OPK_ADD_Y: begin
							state_next.r_iy = add_sum[15:0];
							state_next.r_flags[`FLAG_HALF] = add_low[12];
							state_next.r_flags[`FLAG_CARRY] = add_sum[16];
							state_next.r_flags[`FLAG_SUB] = 1'b0;
						end
						wide_arith_pkg::OPK_INC_PAIR, wide_arith_pkg::OPK_DEC_PAIR: begin
							case (wide_arith_pkg::pair_sel_t'(state_reg.pair_field))
								wide_arith_pkg::SEL_PAIR_B_C: state_next.r_bc = step(state_reg.r_bc,
									state_reg.kind == wide_arith_pkg::OPK_INC_PAIR);
								wide_arith_pkg::SEL_PAIR_D_E: state_next.r_de = step(state_reg.r_de,
									state_reg.kind == wide_arith_pkg::OPK_INC_PAIR);
								wide_arith_pkg::SEL_PAIR_HIGH_LOW: state_next.r_hl = step(state_reg.r_hl,
									state_reg.kind == wide_arith_pkg::OPK_INC_PAIR);
								default: state_next.r_sp = step(state_reg.r_sp,
									state_reg.kind == wide_arith_pkg::OPK_INC_PAIR);
							endcase
						end
						wide_arith_pkg::OPK_INC_X: state_next.r_ix = step(state_reg.r_ix, 1'b1);
						wide_arith_pkg::OPK_DEC_X: state_next.r_ix = step(state_reg.r_ix, 1'b0);
						wide_arith_pkg::OPK_INC_Y: state_next.r_iy = step(state_reg.r_iy, 1'b1);
						wide_arith_pkg::OPK_DEC_Y: state_next.r_iy = step(state_reg.r_iy, 1'b0);
						wide_arith_pkg::OPK_ROT_LC, wide_arith_pkg::OPK_ROT_LT,
						wide_arith_pkg::OPK_ROT_RC, wide_arith_pkg::OPK_ROT_RT: begin
							state_next.r_acc = rot_acc;
							state_next.r_flags[`FLAG_CARRY] = rot_carry;
							state_next.r_flags[`FLAG_HALF] = 1'b0;
							state_next.r_flags[`FLAG_SUB] = 1'b0;
						end
						default: state_next.done = 1'b1;
					endcase
				end
			end
			default: state_next.phase = wide_arith_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign pair_b_c = state_reg.r_bc;
	assign pair_d_e = state_reg.r_de;
	assign pair_high_low = state_reg.r_hl;
	assign stack_pointer = state_reg.r_sp;
	assign index_reg_x = state_reg.r_ix;
	assign index_reg_y = state_reg.r_iy;
	assign acc = state_reg.r_acc;
	assign flags = state_reg.r_flags;
	assign busy = state_reg.busy;
	assign done = state_reg.done;
	assign unknown_op = state_reg.unknown_op;
endmodule
`default_nettype wire

// file: testbench/wide_arith_unit_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wide_arith_unit_asserts (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Requests
	input wire logic op_valid,
	input wire logic [7:0] op_byte,
	input wire logic load_en,
	// Results
	input wire logic [15:0] pair_b_c,
	input wire logic [15:0] index_reg_x,
	input wire logic [15:0] index_reg_y,
	input wire logic [7:0] acc,
	input wire logic [7:0] flags,
	input wire logic busy,
	input wire logic done,
	input wire logic unknown_op
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic take;
	logic plain;
	logic [1:0] pfx_reg;
	assign take = op_valid && !busy && !load_en;
	assign plain = take && pfx_reg == 2'h0;
	// Remembers which prefix the next accepted byte follows
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pfx_reg <= 2'h0;
		end else if (take) begin
			pfx_reg <= {op_byte == 8'hfd, op_byte == 8'hdd};
		end
	end
	sequence s_add_y;
		take && pfx_reg[1] && op_byte[7:6] == 2'h0 && op_byte[3:0] == 4'h9;
	endsequence
	sequence s_inc_x;
		take && pfx_reg[0] && op_byte == 8'h23;
	endsequence
	chk_pair_inc_time: assert property (plain && op_byte == 8'h03 |->
		##1 busy [*5] ##1 done && !busy)
		else $error("pair increment timing wrong");
	chk_pair_inc_value: assert property (plain && op_byte == 8'h03 |->
		##6 pair_b_c == $past(pair_b_c, 6) + 16'h1 && flags == $past(flags, 6))
		else $error("pair increment result wrong");
	chk_pair_dec_value: assert property (plain && op_byte == 8'h0b |->
		##6 done && pair_b_c == $past(pair_b_c, 6) - 16'h1)
		else $error("pair decrement result wrong");
	chk_add_y_time: assert property (s_add_y |-> ##15 done && $past(busy))
		else $error("index add timing wrong");
	chk_add_y_flags: assert property (s_add_y |->
		##15 !flags[1] && ((flags ^ $past(flags, 15)) & 8'hec) == 8'h00)
		else $error("index add flags wrong");
	chk_add_y_self: assert property (take && pfx_reg[1] && op_byte == 8'h29 |->
		##15 index_reg_y == ($past(index_reg_y, 15) << 1))
		else $error("index add to itself wrong");
	chk_index_inc_x: assert property (s_inc_x |->
		##10 done && index_reg_x == $past(index_reg_x, 10) + 16'h1 && flags == $past(flags, 10))
		else $error("index increment wrong");
	chk_index_dec_y: assert property (take && pfx_reg[1] && op_byte == 8'h2b |->
		##10 done && index_reg_y == $past(index_reg_y, 10) - 16'h1)
		else $error("index decrement wrong");
	chk_rot_left_circ: assert property (plain && op_byte == 8'h07 |->
		##4 done && acc == (($past(acc, 4) << 1) | ($past(acc, 4) >> 7)) &&
		flags[0] == acc[0] && !flags[4] && !flags[1])
		else $error("circular left rotate wrong");
	chk_rot_right_thru: assert property (plain && op_byte == 8'h1f |=>
		##3 done && acc == (($past(acc, 4) >> 1) | ($past(flags, 4) << 7)) && !flags[4])
		else $error("right rotate through carry wrong");
	chk_prefix_refused: assert property (take && pfx_reg != 2'h0 &&
		(op_byte == 8'h00 || pfx_reg[0] && op_byte == 8'h09) |=> unknown_op && !busy)
		else $error("unsupported prefixed byte not flagged");
endmodule
bind wide_arith_unit wide_arith_unit_asserts wide_arith_unit_asserts_inst (
	.sys_clk, .rstn, .op_valid, .op_byte, .load_en, .pair_b_c, .index_reg_x, .index_reg_y,
	.acc, .flags, .busy, .done, .unknown_op);
`default_nettype wire

// file: testbench/cpu_wide_arith_and_acc_rotate_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_wide_arith_and_acc_rotate_bench;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic op_valid = 1'b0;
	logic [7:0] op_byte = 8'h00;
	logic load_en = 1'b0;
	logic [15:0] ld [6] = '{default: 16'h0000};
	logic [7:0] ld_acc = 8'h00;
	logic [7:0] ld_flags = 8'h00;
	wire [15:0] vw [6];
	wire [7:0] acc;
	wire [7:0] flags;
	wire busy;
	wire done;
	wire unknown_op;
	logic [15:0] ex [6] = '{default: 16'h0000};
	logic [7:0] ex_acc = 8'h00;
	logic [7:0] ex_flags = 8'h00;
	int error_cnt = 0;
	int samples_checked = 0;
	always #20 sys_clk = ~sys_clk;
	wide_arith_unit wide_arith_unit_inst (
		.sys_clk(sys_clk), .rstn(rstn), .op_valid(op_valid), .op_byte(op_byte),
		.load_en(load_en), .load_pair_b_c(ld[0]), .load_pair_d_e(ld[1]),
		.load_pair_high_low(ld[2]), .load_stack_pointer(ld[3]), .load_index_reg_x(ld[4]),
		.load_index_reg_y(ld[5]), .load_acc(ld_acc), .load_flags(ld_flags),
		.pair_b_c(vw[0]), .pair_d_e(vw[1]), .pair_high_low(vw[2]), .stack_pointer(vw[3]),
		.index_reg_x(vw[4]), .index_reg_y(vw[5]), .acc(acc), .flags(flags), .busy(busy),
		.done(done), .unknown_op(unknown_op)
	);
	task automatic finish_test();
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_all();
		for (int i = 0; i < 6; i++) begin
			cmp("reg", ex[i], vw[i]);
		end
		cmp("acc", {8'h00, ex_acc}, {8'h00, acc});
		cmp("flags", {8'h00, ex_flags}, {8'h00, flags});
	endtask
	task automatic load_all();
		@(posedge sys_clk);
		for (int i = 0; i < 6; i++) begin
			ld[i] <= ex[i];
		end
		ld_acc <= ex_acc;
		ld_flags <= ex_flags;
		load_en <= 1'b1;
		@(posedge sys_clk);
		load_en <= 1'b0;
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge sys_clk);
		op_valid <= 1'b1;
		op_byte <= b;
		@(posedge sys_clk);
		op_valid <= 1'b0;
	endtask
	// Counts cycles from the accepting edge to the done pulse
	task automatic run(input logic [7:0] b, input int n);
		int cnt;
		send(b);
		cnt = 1;
		#1;
		while (done !== 1'b1 && cnt < 40) begin
			@(posedge sys_clk);
			#1;
			cnt++;
		end
		cmp("cycles", 16'(n), 16'(cnt));
		check_all();
	endtask
	task automatic s_pairs();
		for (int k = 0; k < 8; k++) begin
			ex[k % 4] = (k < 4) ? 16'hffff : 16'h0000;
			ex_flags = 8'h5a;
			load_all();
			ex[k % 4] = ~ex[k % 4];
			run({2'h0, 2'(k % 4), (k < 4) ? 4'h3 : 4'hb}, 6);
		end
	endtask
	task automatic s_index();
		logic [15:0] v;
		for (int k = 0; k < 8; k++) begin
			v = k[2] ? 16'h3300 : (k[1] ? 16'h0000 : 16'hffff);
			ex[4 + k[0]] = v;
			ex_flags = 8'hff;
			load_all();
			ex[4 + k[0]] = k[1] ? v - 16'h1 : v + 16'h1;
			send(k[0] ? 8'hfd : 8'hdd);
			run(k[1] ? 8'h2b : 8'h23, 10);
		end
	endtask
	task automatic s_add();
		logic [15:0] av [4] = '{16'h0333, 16'h0fff, 16'h8800, 16'hf000};
		logic [15:0] bv [4] = '{16'h0555, 16'h0001, 16'h8800, 16'h1000};
		logic [16:0] sum;
		logic [12:0] low;
		for (int k = 0; k < 4; k++) begin
			ex[5] = av[k];
			ex[(k == 2) ? 5 : k] = bv[k];
			ex_flags = k[0] ? 8'hff : 8'hc6;
			load_all();
			sum = {1'b0, av[k]} + bv[k];
			low = {1'b0, av[k][11:0]} + {1'b0, bv[k][11:0]};
			ex[5] = sum[15:0];
			ex_flags = (ex_flags & 8'hec) | {3'h0, low[12], 3'h0, sum[16]};
			send(8'hfd);
			run({2'h0, 2'(k), 4'h9}, 15);
		end
	endtask
	task automatic s_rot();
		logic [7:0] a;
		logic c;
		for (int k = 0; k < 8; k++) begin
			a = k[2] ? 8'h10 : 8'he1;
			ex_acc = a;
			ex_flags = k[2] ? 8'hd7 : 8'h3a;
			load_all();
			c = ex_flags[0];
			ex_acc = k[1] ? {k[0] ? c : a[0], a[7:1]} : {a[6:0], k[0] ? c : a[7]};
			ex_flags = (ex_flags & 8'hec) | {7'h0, k[1] ? a[0] : a[7]};
			run({3'h0, k[0], k[1], 3'h7}, 4);
		end
	endtask
	// A byte offered while busy is dropped; bad prefixed bytes are flagged
	task automatic s_misc();
		ex_acc = 8'h81;
		load_all();
		ex[0] = ex[0] + 16'h1;
		send(8'h03);
		run(8'h07, 4);
		repeat (6) @(posedge sys_clk);
		#1;
		check_all();
		send(8'hfd);
		send(8'h00);
		#1;
		cmp("unknown", 16'h1, {15'h0, unknown_op});
		send(8'hdd);
		send(8'h09);
		#1;
		cmp("unknown", 16'h1, {15'h0, unknown_op});
		ex[0] = ex[0] + 16'h1;
		run(8'h03, 6);
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		#1;
		check_all();
		cmp("busy", 16'h0, {15'h0, busy});
		cmp("done", 16'h0, {15'h0, done});
		ex = '{16'h1111, 16'h2222, 16'h3333, 16'h4444, 16'h5555, 16'h6666};
		s_pairs();
		s_index();
		s_add();
		s_rot();
		s_misc();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		finish_test();
	end
endmodule
`default_nettype wire
